// ---- logic/gcr_regs.svh ----
// Register offsets, fields, reset values and timing counts of the global configuration bank
`ifndef GCR_REGS_SVH
`define GCR_REGS_SVH

`define GCR_ADDR_W            15
`define GCR_OFF_IFACE_SETUP   15'h0000
`define GCR_OFF_POWER_STATE   15'h0002
`define GCR_OFF_DEVICE_CLASS  15'h0003
`define GCR_OFF_FILTER_B_LAST 15'h0459

`define GCR_BIT_RESTART       7
`define GCR_BIT_RSVD6         6
`define GCR_BIT_ASCEND        5
`define GCR_BIT_SDO_ONLY      4

`define GCR_RST_IFACE_SETUP   8'h30
`define GCR_RST_POWER_STATE   8'h00
`define GCR_RST_CLASS_UPPER   4'h0
`define GCR_RST_FILTER_B_LAST 16'h0000

// Arbitrary neutral class code
`define GCR_CLASS_CODE        4'h5

`define GCR_RESTART_NS        750
`define GCR_CLK_PERIOD_NS     20
`define GCR_RESTART_CYCLES    ((`GCR_RESTART_NS + `GCR_CLK_PERIOD_NS - 1) / `GCR_CLK_PERIOD_NS)

`endif

// ---- logic/gcr_pkg.sv ----
// Types shared by the global configuration bank
package gcr_pkg;

  typedef enum logic [1:0] {
    GCR_PWR_NORMAL = 2'h0,
    GCR_PWR_RSVD1  = 2'h1,
    GCR_PWR_RSVD2  = 2'h2,
    GCR_PWR_DOWN   = 2'h3
  } gcr_pwr_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [15:0] wdata;
  } gcr_req_t;

  typedef struct packed {
    logic        addr_ascend;
    logic        sdo_only;
    gcr_pwr_t    power_state;
    logic        power_down;
    logic        chip_reset;
  } gcr_cfg_t;

endpackage : gcr_pkg

// ---- logic/gcr_restart_timer.sv ----
// Self-clearing full-chip restart sequencer
`timescale 1ns/1ps
`include "gcr_regs.svh"

module gcr_restart_timer
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy
);
  import gcr_pkg::*;

  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(`GCR_RESTART_CYCLES - 1);

  typedef enum logic {GCR_T_IDLE, GCR_T_RUN} gcr_tstate_t;

  gcr_tstate_t      state;
  gcr_tstate_t      next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  wire              at_end = (count == LAST);

  always_comb
  begin
    next_state = state;
    next_count = count;
    unique case (state)
      GCR_T_IDLE:
      begin
        next_count = '0;
        if (start)
          next_state = GCR_T_RUN;
      end
      GCR_T_RUN:
      begin
        next_count = count + CNT_W'(1);
        if (at_end)
          next_state = GCR_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= GCR_T_IDLE;
      count <= '0;
      busy  <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      count <= next_count;
      busy  <= (next_state == GCR_T_RUN);
    end
  end

endmodule : gcr_restart_timer

// ---- logic/gcr_bank.sv ----
// Global configuration register bank of the converter's serial interface
// What this block does
// - Restart bit seven resets chip and registers
// - Restart bit clears itself, reads back zero
// - Bit five selects address increment or decrement
// - Bit four reads one; reads only on SDO
// - Power field: zero normal, three power down
// - Class field returns fixed high-speed converter code
`timescale 1ns/1ps
`include "gcr_regs.svh"

module gcr_bank
(
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         clk_en,
  input  wire gcr_pkg::gcr_req_t req,
  output logic [15:0]       rdata,
  output logic              rvalid,
  output gcr_pkg::gcr_cfg_t cfg,
  output logic              restart_busy
);
  import gcr_pkg::*;

  // Reset images of the stored registers
  localparam logic [7:0]  SETUP_RST  = `GCR_RST_IFACE_SETUP;
  localparam logic [7:0]  POWER_RST  = `GCR_RST_POWER_STATE;
  localparam logic [3:0]  CLASS_RST  = `GCR_RST_CLASS_UPPER;
  localparam logic [15:0] FILTER_RST = `GCR_RST_FILTER_B_LAST;

  // Configuration outputs as they stand in reset
  localparam gcr_cfg_t    CFG_RST    = '{addr_ascend: SETUP_RST[`GCR_BIT_ASCEND],
                                         sdo_only:    1'b1,
                                         power_state: gcr_pwr_t'(POWER_RST[1:0]),
                                         power_down:  1'b0,
                                         chip_reset:  1'b0};

  logic        ascend;
  logic        rsvd6;
  logic [3:0]  setup_low;
  logic [7:0]  power_reg;
  logic [3:0]  class_upper;
  logic [15:0] filter_b_last;
  logic        busy;
  gcr_pwr_t    next_mode;
  gcr_cfg_t    next_cfg;

  // Address match of one mapped register
  function automatic logic addr_hit
  (
    input logic [`GCR_ADDR_W-1:0] addr,
    input logic [`GCR_ADDR_W-1:0] offset
  );
    return (addr == offset);
  endfunction : addr_hit

  // Places an 8-bit register image on the low byte of the read bus
  function automatic logic [15:0] byte_view
  (
    input logic [7:0] value
  );
    return {8'h00, value};
  endfunction : byte_view

  wire hit_setup  = addr_hit(req.addr, `GCR_OFF_IFACE_SETUP);
  wire hit_power  = addr_hit(req.addr, `GCR_OFF_POWER_STATE);
  wire hit_class  = addr_hit(req.addr, `GCR_OFF_DEVICE_CLASS);
  wire hit_filter = addr_hit(req.addr, `GCR_OFF_FILTER_B_LAST);

  wire wr_setup  = req.wr && hit_setup;
  wire wr_power  = req.wr && hit_power;
  wire wr_class  = req.wr && hit_class;
  wire wr_filter = req.wr && hit_filter;

  // Restart request; refused while an earlier restart still runs
  wire restart_req = wr_setup && req.wdata[`GCR_BIT_RESTART] && !restart_busy;
  // Restart in flight: the write edge and the whole timer run
  wire restart_run = restart_req || busy;
  // Bank held at reset values, writes refused, while the busy flag stands
  wire bank_clr    = restart_req || restart_busy;

  // Bit 7 always reads zero since the restart self-clears
  wire [7:0] setup_view = {1'b0, rsvd6, ascend, 1'b1, setup_low};
  wire [7:0] class_view = {class_upper, `GCR_CLASS_CODE};

  // Read path: registered data and a one-cycle valid pulse
  wire [15:0] read_mux =
    hit_setup  ? byte_view(setup_view) :
    hit_power  ? byte_view(power_reg)  :
    hit_class  ? byte_view(class_view) :
    hit_filter ? filter_b_last         :
                 16'h0000;
  wire [15:0] next_rdata = req.rd ? read_mux : rdata;

  // Next register contents: restart clear first, then a host write
  wire        next_ascend =
    bank_clr ? SETUP_RST[`GCR_BIT_ASCEND] :
    wr_setup ? req.wdata[`GCR_BIT_ASCEND] :
               ascend;
  wire        next_rsvd6 =
    bank_clr ? SETUP_RST[`GCR_BIT_RSVD6] :
    wr_setup ? req.wdata[`GCR_BIT_RSVD6] :
               rsvd6;
  wire [3:0]  next_setup_low =
    bank_clr ? SETUP_RST[3:0] :
    wr_setup ? req.wdata[3:0] :
               setup_low;
  wire [7:0]  next_power_reg =
    bank_clr ? POWER_RST :
    wr_power ? req.wdata[7:0] :
               power_reg;
  wire [3:0]  next_class_upper =
    bank_clr ? CLASS_RST :
    wr_class ? req.wdata[7:4] :
               class_upper;
  wire [15:0] next_filter_b_last =
    bank_clr  ? FILTER_RST :
    wr_filter ? req.wdata :
                filter_b_last;

  // Configuration outputs follow the register contents of the same edge
  assign next_mode = gcr_pwr_t'(next_power_reg[1:0]);

  assign next_cfg = '{addr_ascend: next_ascend,
                      sdo_only:    1'b1,
                      power_state: next_mode,
                      power_down:  (next_mode == GCR_PWR_DOWN),
                      chip_reset:  restart_run};

  gcr_restart_timer u_timer
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .start   (restart_req),
    .busy    (busy)
  );

  // Stored register fields
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ascend <= SETUP_RST[`GCR_BIT_ASCEND];
    else if (clk_en)
      ascend <= next_ascend;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rsvd6 <= SETUP_RST[`GCR_BIT_RSVD6];
    else if (clk_en)
      rsvd6 <= next_rsvd6;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      setup_low <= SETUP_RST[3:0];
    else if (clk_en)
      setup_low <= next_setup_low;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      power_reg <= POWER_RST;
    else if (clk_en)
      power_reg <= next_power_reg;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      class_upper <= CLASS_RST;
    else if (clk_en)
      class_upper <= next_class_upper;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      filter_b_last <= FILTER_RST;
    else if (clk_en)
      filter_b_last <= next_filter_b_last;
  end

  // Output flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 16'h0000;
    else if (clk_en)
      rdata <= next_rdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rvalid <= 1'b0;
    else if (clk_en)
      rvalid <= req.rd;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cfg <= CFG_RST;
    else if (clk_en)
      cfg <= next_cfg;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      restart_busy <= 1'b0;
    else if (clk_en)
      restart_busy <= restart_run;
  end

endmodule : gcr_bank

// ---- tb/gcr_bank_chk.sv ----
// Port assertions of the global configuration bank
`timescale 1ns/1ps
`include "gcr_regs.svh"
module gcr_bank_chk
(
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              clk_en,
  input wire gcr_pkg::gcr_req_t req,
  input wire logic [15:0]       rdata,
  input wire logic              rvalid,
  input wire gcr_pkg::gcr_cfg_t cfg,
  input wire logic              restart_busy
);
  import gcr_pkg::*;
  wire logic rd = clk_en && req.rd;
  wire logic wr = clk_en && req.wr && !restart_busy;
  wire logic w0 = wr && req.addr == `GCR_OFF_IFACE_SETUP;
  logic [7:0] busy_len;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      busy_len <= 8'h00;
    else if (clk_en)
      busy_len <= restart_busy ? busy_len + 8'h01 : 8'h00;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  restart_entry_a: assert property (w0 && req.wdata[7] |=> restart_busy && cfg.addr_ascend && cfg.power_state == 2'h0)
    else $error("restart entry wrong");
  restart_len_a: assert property ($rose(restart_busy) |-> restart_busy[*8] ##[31:32] !restart_busy)
    else $error("restart length wrong");
  ascend_wr_a: assert property (w0 && !req.wdata[7] |=> cfg.addr_ascend == $past(req.wdata[5]))
    else $error("step direction wrong");
  sdo_only_a: assert property (cfg.sdo_only)
    else $error("output pin flag low");
  setup_rd_a: assert property (rd && req.addr == `GCR_OFF_IFACE_SETUP |=> rvalid && !rdata[7] && rdata[4])
    else $error("setup read wrong");
  power_wr_a: assert property (wr && req.addr == `GCR_OFF_POWER_STATE |=> cfg.power_state == $past(req.wdata[1:0]))
    else $error("power field wrong");
  power_down_a: assert property (cfg.power_down == (cfg.power_state == GCR_PWR_DOWN))
    else $error("power down wrong");
  class_rd_a: assert property (rd && req.addr == `GCR_OFF_DEVICE_CLASS |=> rdata[3:0] == `GCR_CLASS_CODE)
    else $error("class code wrong");
  restart_span_a: assert property ($fell(restart_busy) |-> busy_len == 8'(`GCR_RESTART_CYCLES + 1))
    else $error("restart span wrong");
  clk_freeze_a: assert property (!clk_en |=> $stable(cfg) && $stable(rdata) && $stable(rvalid) && $stable(restart_busy))
    else $error("state moved while clock enable low");
endmodule : gcr_bank_chk
bind gcr_bank gcr_bank_chk chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata(rdata),
  .rvalid(rvalid), .cfg(cfg), .restart_busy(restart_busy));

// ---- tb/gcr_host.sv ----
// Host model issuing register requests
`timescale 1ns/1ps
module gcr_host
(
  input  wire logic         ref_clk,
  output gcr_pkg::gcr_req_t req
);
  import gcr_pkg::*;
  initial req = '0;
  task xfer(input logic w, input logic [14:0] a, input logic [15:0] d);
    req = '{w, !w, a, d};
    @(negedge ref_clk);
    req = '{1'b0, 1'b0, ~a, ~d};
    @(negedge ref_clk);
  endtask : xfer
endmodule : gcr_host

// ---- tb/tb_gcr_bank.sv ----
// Testbench of the global configuration bank
`timescale 1ns/1ps
`include "gcr_regs.svh"
module tb_gcr_bank;
  import gcr_pkg::*;
  logic        ref_clk = 0;
  logic        rstn = 0;
  logic        clk_en = 1;
  logic [15:0] rdata;
  logic        rvalid;
  logic        busy;
  gcr_req_t    req;
  gcr_cfg_t    cfg;
  int          n_fail = 0;
  int          comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  gcr_bank dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata(rdata), .rvalid(rvalid),
    .cfg(cfg), .restart_busy(busy));
  gcr_host host (.ref_clk(ref_clk), .req(req));
  task check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  task rchk(input logic [14:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000);
    check(rdata, e);
  endtask : rchk
  task finish_test;
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #20000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rstn = 1;
    rchk(15'h0000, 16'h0030);
    rchk(15'h0003, {12'h000, `GCR_CLASS_CODE});
    rchk(15'h0001, 16'h0000);
    $display("test reset values done");
    host.xfer(1'b1, 15'h0000, 16'h004F);
    rchk(15'h0000, 16'h005F);
    check({15'h0000, cfg.addr_ascend}, 16'h0000);
    host.xfer(1'b1, 15'h0003, 16'h00FA);
    rchk(15'h0003, {12'h00F, `GCR_CLASS_CODE});
    host.xfer(1'b1, 15'h0459, 16'hBEEF);
    rchk(15'h0459, 16'hBEEF);
    $display("test field access done");
    for (int v = 0; v < 4; v++)
    begin
      host.xfer(1'b1, 15'h0002, 16'(v));
      rchk(15'h0002, 16'(v));
      check({15'h0000, cfg.power_down}, {15'h0000, v == 3});
    end
    $display("test power modes done");
    host.xfer(1'b1, 15'h0000, 16'h0080);
    check({15'h0000, busy}, 16'h0001);
    repeat (40) @(negedge ref_clk);
    check({15'h0000, busy}, 16'h0000);
    rchk(15'h0000, 16'h0030);
    rchk(15'h0002, 16'h0000);
    rchk(15'h0459, 16'h0000);
    rchk(15'h0003, {12'h000, `GCR_CLASS_CODE});
    $display("test restart done");
    clk_en = 0;
    host.xfer(1'b1, 15'h0002, 16'h0003);
    clk_en = 1;
    rchk(15'h0002, 16'h0000);
    check({15'h0000, cfg.power_down}, 16'h0000);
    $display("test clock enable done");
    finish_test;
  end
endmodule : tb_gcr_bank
